/* File: verilog/readout_pkg.sv */
/*
 Shared constants, carriers and state codes of the chamber readout controller.
 Assumes a 20 MHz system clock; imported by every design file but the synchroniser.
*/
// Summary of operation
// - Up to 16 cards, 256 wires per stream
// - Four streams served together, 1024 wires
// - Transfer running past 16 us is flagged late
// - 16-bit word: eight hits, 7-bit location, parity flag
// - Store only groups with a hit in stream mode zero
// - Fast clear discards, slow clear aborts
// - Read request starts moving card data
// - All streams shift together during dead time
// - Abort clears data and returns to idle
// - Calibrate level holds calibration mode
// - Busy is OR of stream busies
// - Stream 0 returned clock times readout
// - Stream mode zero selects normal data
// - Width, separation and 2-bit calibrate mode
// - Settings writable and read back
// - Test enable fires one-shot on window edge
// - Three diagnostic ORs over 16 channels
// - Ninth bit carries odd parity
`default_nettype none
package readout_pkg;
    localparam int              CLK_NS         = 50;
    localparam int              STREAMS        = 4;
    localparam int              CHANNELS       = 16;
    localparam int              CARD_W         = 5;
    localparam logic [4:0]      CARD_MAX       = 5'h10;
    localparam int              BITS_PER_CARD  = 18;
    localparam int              NBITS_W        = 9;
    localparam int              POS_W          = 4;
    localparam logic [3:0]      POS_LAST       = 4'h8;
    localparam int              HITS           = 8;
    localparam int              GRP_W          = 5;
    localparam int              LOC_W          = 7;
    localparam int              MEM_DEPTH      = 128;
    localparam int              CNT_W          = 8;
    localparam int              XFER_LIMIT_NS  = 16000;
    localparam int              XFER_LIMIT_CYC = XFER_LIMIT_NS / CLK_NS;
    localparam int              XFER_W         = 9;
    localparam int              CAL_PERIOD_NS  = 10000;
    localparam int              CAL_PERIOD_CYC = CAL_PERIOD_NS / CLK_NS;
    localparam logic [7:0]      CAL_LAST       = 8'(CAL_PERIOD_CYC - 1);
    localparam logic [9:0]      PAIR_START     = 10'h001;
    localparam logic [3:0]      MODE_NORMAL    = 4'h0;
    localparam int              CALM_PAIR      = 0;
    localparam int              CALM_CLEAR     = 1;

    typedef struct packed {
        logic                   perr;
        logic [LOC_W-1:0]       loc;
        logic [HITS-1:0]        hits;
    } hit_word_t;

    typedef struct packed {
        logic [STREAMS-1:0][CARD_W-1:0] cards;
        logic [3:0]             stream_mode;
        logic [7:0]             cal_width;
        logic [7:0]             cal_sep;
        logic [1:0]             cal_mode;
        logic [CHANNELS-1:0]    test_en;
    } cfg_t;

    typedef struct packed {
        logic                   ret_clk;
        logic [STREAMS-1:0]     data;
        logic                   read;
        logic                   abort;
        logic                   cal;
        logic                   fclr;
    } ctl_pins_t;

    typedef struct packed {
        logic                   window;
        logic [CHANNELS-1:0]    comp;
        logic [CHANNELS-1:0]    delay;
        logic [CHANNELS-1:0]    latch;
    } card_pins_t;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'h1,
        ST_SHIFT = 3'h2,
        ST_CAL   = 3'h4
    } seq_t;
endpackage : readout_pkg
`default_nettype wire

/* File: verilog/pin_sync.sv */
/*
 Three-stage input synchroniser with agreement filter.
 Assumes inputs asynchronous to mclk_in; output changes once stages two
 and three agree.
*/
`timescale 1ns/1ns
`default_nettype none
module pin_sync #(
    parameter int W = 1
) (
    input  wire logic         mclk_in,
    input  wire logic         rst_n_in,
    input  wire logic [W-1:0] d_in,
    output logic      [W-1:0] q_out
);
    logic [W-1:0] s1_r;
    logic [W-1:0] s2_r;
    logic [W-1:0] s3_r;
    logic [W-1:0] q_r;
    logic [W-1:0] q_nxt;

    // Take stage three where stages agree, else hold
    assign q_nxt = (s2_r & s3_r) | (q_r & (s2_r ^ s3_r));
    assign q_out = q_r;

    // Synchroniser chain
    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
            q_r  <= '0;
        end else begin
            s1_r <= d_in;
            s2_r <= s1_r;
            s3_r <= s2_r;
            q_r  <= q_nxt;
        end
    end
endmodule : pin_sync
`default_nettype wire

/* File: verilog/stream_unpack.sv */
/*
 One readout stream: counts chain bits, assembles chip groups, checks parity
 and holds one formatted word until the writer takes it.
 Assumes shift_in marks a returned-clock edge with bit_in valid.
*/
`timescale 1ns/1ns
`default_nettype none
module stream_unpack
    import readout_pkg::*;
#(
    parameter logic [1:0] IDX = 2'h0
) (
    input  wire logic              mclk_in,
    input  wire logic              rst_n_in,
    input  wire logic              start_in,
    input  wire logic              abort_in,
    input  wire logic              shift_in,
    input  wire logic              bit_in,
    input  wire logic              keep_all_in,
    input  wire logic              ack_in,
    input  wire logic [CARD_W-1:0] cards_in,
    output logic                   busy_out,
    output logic                   pend_out,
    output hit_word_t              word_out
);
    logic [NBITS_W-1:0] left_r;
    logic [POS_W-1:0]   pos_r;
    logic [GRP_W-1:0]   grp_r;
    logic [HITS-1:0]    sh_r;
    logic               pend_r;
    hit_word_t          word_r;

    // Chain length from the clamped card count
    wire logic [CARD_W-1:0]  cards_w = (cards_in > CARD_MAX) ? CARD_MAX : cards_in;
    wire logic [NBITS_W-1:0] load_w  = NBITS_W'(cards_w * BITS_PER_CARD);
    wire logic take_w = shift_in && (left_r != '0);
    wire logic last_w = take_w && (pos_r == POS_LAST);
    wire logic emit_w = last_w && ((|sh_r) || keep_all_in);
    wire logic perr_w = ~^{sh_r, bit_in};

    assign busy_out = (left_r != '0) | pend_r;
    assign pend_out = pend_r;
    assign word_out = word_r;

    // Bit counting, group assembly and word hold
    always_ff @(posedge mclk_in) begin
        if (!rst_n_in || abort_in) begin
            left_r <= '0;
            pos_r  <= '0;
            grp_r  <= '0;
            sh_r   <= '0;
            pend_r <= 1'b0;
            word_r <= '0;
        end else begin
            if (start_in) begin
                left_r <= load_w;
                pos_r  <= '0;
                grp_r  <= '0;
                sh_r   <= '0;
            end else if (take_w) begin
                left_r <= left_r - 1'b1;
                pos_r  <= last_w ? '0 : pos_r + 1'b1;
                grp_r  <= last_w ? grp_r + 1'b1 : grp_r;
                sh_r   <= last_w ? '0 : {sh_r[HITS-2:0], bit_in};
            end
            pend_r <= emit_w | (pend_r & ~ack_in);
            if (emit_w) begin
                word_r <= '{perr: perr_w, loc: {IDX, grp_r}, hits: sh_r};
            end
        end
    end
endmodule : stream_unpack
`default_nettype wire

/* File: verilog/chamber_readout_control.sv */
/*
 Chamber readout controller and system driver: four card streams,
 formatted hit memory, read/abort/calibrate sequencing, test outputs and
 card diagnostic ORs.
 Assumes all pin inputs asynchronous to mclk_in; settings and host read
 index come from logic on mclk_in.
*/
`timescale 1ns/1ns
`default_nettype none
module chamber_readout_control
    import readout_pkg::*;
(
    input  wire logic             mclk_in,
    input  wire logic             rst_n_in,
    input  wire ctl_pins_t        ctl_pins_in,
    input  wire card_pins_t       card_pins_in,
    input  wire logic             cfg_wr_in,
    input  wire cfg_t             cfg_in,
    input  wire logic [LOC_W-1:0] rd_index_in,
    output cfg_t                  cfg_rdback_out,
    output hit_word_t             rd_word_out,
    output logic [CNT_W-1:0]      word_count_out,
    output logic                  busy_out,
    output logic                  xfer_load_out,
    output logic                  xfer_done_out,
    output logic                  xfer_late_out,
    output logic                  parity_err_out,
    output logic                  cal_active_out,
    output logic                  test_window_out,
    output logic                  test_discard_out,
    output logic                  prompt_or_out,
    output logic                  delayed_or_out,
    output logic                  latched_or_out
);
    localparam int CAL_EXIT_BOUND = 2 * CAL_PERIOD_CYC + 2;
    localparam logic [XFER_W-1:0] XFER_LIMIT = XFER_W'(XFER_LIMIT_CYC);

    ctl_pins_t           ctl_q;
    ctl_pins_t           ctl_prev_r;
    ctl_pins_t           rise_w;
    card_pins_t          card_q;
    logic                win_prev_r;
    logic [CHANNELS-1:0] comp_prev_r;
    cfg_t                cfg_r;
    seq_t                st_r;
    seq_t                st_nxt;
    logic [STREAMS-1:0]  sbusy_w;
    logic [STREAMS-1:0]  pend_w;
    logic [STREAMS-1:0]  ack_w;
    hit_word_t           words_w [STREAMS];
    hit_word_t           sel_word;
    hit_word_t           mem_r [MEM_DEPTH];
    hit_word_t           rd_word_r;
    logic [CNT_W-1:0]    wcnt_r;
    logic                load_r;
    logic                done_r;
    logic                late_r;
    logic                perr_r;
    logic [XFER_W-1:0]   xcyc_r;
    logic [7:0]          cal_cnt_r;
    logic                cal_stop_r;
    logic                win_r;
    logic                disc_r;
    logic [CHANNELS-1:0] oneshot_r;
    logic                prompt_r;
    logic                delayed_r;
    logic                latched_r;

    // Pin synchronisers for link, trigger and card lines
    pin_sync #(.W($bits(ctl_pins_t))) u_ctl_sync (
        .mclk_in  (mclk_in),
        .rst_n_in (rst_n_in),
        .d_in     (ctl_pins_in),
        .q_out    (ctl_q)
    );

    pin_sync #(.W($bits(card_pins_t))) u_card_sync (
        .mclk_in  (mclk_in),
        .rst_n_in (rst_n_in),
        .d_in     (card_pins_in),
        .q_out    (card_q)
    );

    // Rising edges of the filtered pins
    assign rise_w = ctl_pins_t'(ctl_q & ~ctl_prev_r);

    // Sequencer decodes
    wire logic idle_w   = (st_r == ST_IDLE);
    wire logic shift_st = (st_r == ST_SHIFT);
    wire logic cal_st   = (st_r == ST_CAL);
    wire logic read_go  = idle_w && rise_w.read && !ctl_q.cal
                          && (cfg_r.cards[0] != '0);
    wire logic cal_go   = idle_w && ctl_q.cal && !read_go;
    wire logic abort_go = shift_st && rise_w.abort;
    wire logic xfer_end = shift_st && !(|sbusy_w) && !abort_go;
    wire logic cal_end  = cal_st && (cal_cnt_r == CAL_LAST)
                          && (cal_stop_r || !ctl_q.cal);
    wire logic shift_w  = shift_st && rise_w.ret_clk;
    wire logic keep_all = (cfg_r.stream_mode != MODE_NORMAL);
    wire logic wr_en    = |pend_w;

    // Stream 0 return clock paces every stream together
    for (genvar i = 0; i < STREAMS; i++) begin : g_stream
        stream_unpack #(.IDX(2'(i))) u_stream (
            .mclk_in     (mclk_in),
            .rst_n_in    (rst_n_in),
            .start_in    (read_go),
            .abort_in    (abort_go),
            .shift_in    (shift_w),
            .bit_in      (ctl_q.data[i]),
            .keep_all_in (keep_all),
            .ack_in      (ack_w[i]),
            .cards_in    (cfg_r.cards[i]),
            .busy_out    (sbusy_w[i]),
            .pend_out    (pend_w[i]),
            .word_out    (words_w[i])
        );
    end

    // Lowest pending stream is written first
    assign ack_w = pend_w & (~pend_w + 4'h1);

    // Select the acknowledged stream's word
    always_comb begin
        sel_word = '0;
        for (int i = 0; i < STREAMS; i++) begin
            if (ack_w[i]) begin
                sel_word = words_w[i];
            end
        end
    end

    // Busy is the OR of stream busies
    assign busy_out       = |sbusy_w;
    assign word_count_out = wcnt_r;
    assign rd_word_out    = rd_word_r;
    assign cfg_rdback_out = cfg_r;
    assign xfer_load_out  = load_r;
    assign xfer_done_out  = done_r;
    assign xfer_late_out  = late_r;
    assign parity_err_out = perr_r;
    assign cal_active_out = cal_st;
    assign test_window_out  = win_r;
    assign test_discard_out = disc_r;
    assign prompt_or_out  = prompt_r;
    assign delayed_or_out = delayed_r;
    assign latched_or_out = latched_r;

    // Next sequencer state
    always_comb begin
        case (st_r)
            ST_IDLE: begin
                if (read_go) begin
                    st_nxt = ST_SHIFT;
                end else if (cal_go) begin
                    st_nxt = ST_CAL;
                end else begin
                    st_nxt = ST_IDLE;
                end
            end
            ST_SHIFT: begin
                st_nxt = (abort_go || xfer_end) ? ST_IDLE : ST_SHIFT;
            end
            ST_CAL: begin
                st_nxt = cal_end ? ST_IDLE : ST_CAL;
            end
            default: begin
                st_nxt = ST_IDLE;
            end
        endcase
    end

    // Sequencer state and pin history
    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            st_r        <= ST_IDLE;
            ctl_prev_r  <= '0;
            win_prev_r  <= 1'b0;
            comp_prev_r <= '0;
        end else begin
            st_r        <= st_nxt;
            ctl_prev_r  <= ctl_q;
            win_prev_r  <= card_q.window;
            comp_prev_r <= card_q.comp;
        end
    end

    // Settings are taken only while idle and always read back
    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            cfg_r <= '0;
        end else if (cfg_wr_in && idle_w) begin
            cfg_r <= cfg_in;
        end
    end

    // Hit memory: cleared on abort, filled one word a cycle
    always_ff @(posedge mclk_in) begin
        if (!rst_n_in || abort_go) begin
            wcnt_r <= '0;
            for (int i = 0; i < MEM_DEPTH; i++) begin
                mem_r[i] <= '0;
            end
        end else if (read_go) begin
            wcnt_r <= '0;
        end else if (wr_en) begin
            mem_r[wcnt_r[LOC_W-1:0]] <= sel_word;
            wcnt_r <= wcnt_r + 1'b1;
        end
    end

    // Host read port
    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            rd_word_r <= '0;
        end else begin
            rd_word_r <= mem_r[rd_index_in];
        end
    end

    // Transfer strobes, time budget and parity flag
    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            load_r <= 1'b0;
            done_r <= 1'b0;
            late_r <= 1'b0;
            perr_r <= 1'b0;
            xcyc_r <= '0;
        end else begin
            load_r <= read_go;
            done_r <= xfer_end;
            xcyc_r <= read_go ? '0 :
                      (shift_st && xcyc_r != XFER_LIMIT) ? xcyc_r + 1'b1 : xcyc_r;
            late_r <= !read_go && (late_r || (shift_st && xcyc_r == XFER_LIMIT));
            perr_r <= !read_go && (perr_r || (wr_en && sel_word.perr));
        end
    end

    // Calibration pulse-pair timing
    wire logic [9:0] c_w  = {2'h0, cal_cnt_r};
    wire logic [9:0] w_w  = {2'h0, cfg_r.cal_width};
    wire logic [9:0] p2_w = PAIR_START + {2'h0, cfg_r.cal_sep};
    wire logic pair_w = ((c_w >= PAIR_START) && (c_w < PAIR_START + w_w))
                        || ((c_w >= p2_w) && (c_w < p2_w + w_w));
    wire logic win_nxt  = cal_st && cfg_r.cal_mode[CALM_PAIR] && pair_w;
    wire logic disc_nxt = (idle_w && rise_w.fclr)
                          || (cal_st && cfg_r.cal_mode[CALM_CLEAR] && cal_cnt_r == '0);

    // Calibration cycle counter and test outputs
    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            cal_cnt_r  <= '0;
            cal_stop_r <= 1'b0;
            win_r      <= 1'b0;
            disc_r     <= 1'b0;
        end else begin
            cal_cnt_r  <= (!cal_st || cal_cnt_r == CAL_LAST) ? '0 : cal_cnt_r + 1'b1;
            cal_stop_r <= cal_st && !cal_end && (cal_stop_r || !ctl_q.cal);
            win_r      <= win_nxt;
            disc_r     <= disc_nxt;
        end
    end

    // Card channel one-shots and diagnostic ORs
    wire logic                win_rise  = card_q.window && !win_prev_r;
    wire logic [CHANNELS-1:0] comp_rise = card_q.comp & ~comp_prev_r;
    wire logic [CHANNELS-1:0] trig_w = (cfg_r.test_en & {CHANNELS{win_rise}})
                                       | (~cfg_r.test_en & comp_rise);

    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            oneshot_r <= '0;
            prompt_r  <= 1'b0;
            delayed_r <= 1'b0;
            latched_r <= 1'b0;
        end else begin
            oneshot_r <= trig_w;
            prompt_r  <= |oneshot_r;
            delayed_r <= |card_q.delay;
            latched_r <= |card_q.latch;
        end
    end

    // Checks
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!rst_n_in);

    AST_BUSY_ON_READ: assert property (
        read_go |=> busy_out && shift_st
    ) else $error("busy not raised after accepted read");

    AST_LOAD_PULSE: assert property (
        read_go |=> xfer_load_out ##1 !xfer_load_out
    ) else $error("load pulse missing or too long");

    AST_ABORT_CLEARS: assert property (
        abort_go |=> (word_count_out == '0) && idle_w && !busy_out
    ) else $error("abort did not clear and idle");

    AST_ZERO_SUPPRESS: assert property (
        wr_en && !keep_all |-> sel_word.hits != '0
    ) else $error("empty group stored in normal mode");

    AST_NORMAL_MODE: assert property (
        wr_en && (cfg_r.stream_mode == MODE_NORMAL) |-> |sel_word.hits
    ) else $error("empty group stored in mode zero");

    AST_CAL_ENTER: assert property (
        idle_w && ctl_q.cal && !rise_w.read |=> cal_st
    ) else $error("calibrate level ignored");

    AST_CAL_EXIT: assert property (
        cal_st && !ctl_q.cal |-> ##[1:CAL_EXIT_BOUND] idle_w
    ) else $error("calibration did not end in time");

    AST_NO_LOAD_IN_CAL: assert property (
        cal_st |-> !xfer_load_out && !busy_out
    ) else $error("readout during calibration");

    AST_PARITY_FLAG: assert property (
        wr_en && sel_word.perr |=> parity_err_out
    ) else $error("parity error not flagged");

    AST_LATE_FLAG: assert property (
        shift_st && xcyc_r == XFER_LIMIT |=> xfer_late_out
    ) else $error("transfer overrun not flagged");

    AST_DONE_PULSE: assert property (
        $fell(busy_out) && !$past(abort_go) |=> xfer_done_out
    ) else $error("done pulse missing at end of busy");

    AST_TEST_ONESHOT: assert property (
        win_rise && (|cfg_r.test_en) |=> (|oneshot_r) ##1 prompt_or_out
    ) else $error("test enable did not fire one-shot");

    AST_WINDOW_ONLY_CAL: assert property (
        test_window_out |-> $past(cal_st) && cfg_r.cal_mode[CALM_PAIR]
    ) else $error("test window outside calibration");
endmodule : chamber_readout_control
`default_nettype wire

/* File: tb/card_chain_model.sv */
/*
 Behavioural chain of chamber cards on four streams, seen from the controller.
 Assumes go_in is the controller's transfer strobe and stop_in its abort pin.
*/
`timescale 1ns/1ns
`default_nettype none
module card_chain_model
    import readout_pkg::*;
(
    input  wire logic                           go_in,
    input  wire logic                           stop_in,
    input  wire logic [STREAMS-1:0][CARD_W-1:0] cards_in,
    input  wire logic [STREAMS-1:0][31:0][8:0]  img_in,
    output logic                                ret_clk_out,
    output logic [STREAMS-1:0]                  data_out
);
    int n;
    int s;
    int mx;

    // Idle lines: returned clock stands low between frames
    initial begin
        ret_clk_out = 1'b0;
        data_out    = '0;
    end

    // Shift chips out, eight hits then parity, one bit per returned clock
    always @(posedge go_in) begin
        mx = 0;
        for (s = 0; s < STREAMS; s++)
            if (cards_in[s] > mx) mx = cards_in[s];
        for (n = 0; n < BITS_PER_CARD * mx && !stop_in; n++) begin
            for (s = 0; s < STREAMS; s++)
                data_out[s] = (n < BITS_PER_CARD * cards_in[s]) ?
                    img_in[s][n / 9][8 - n % 9] : ~data_out[s];
            #200 ret_clk_out = 1'b1;
            #200 ret_clk_out = 1'b0;
        end
        data_out = ~data_out;  // Released lines no longer show the last bit
    end
endmodule : card_chain_model
`default_nettype wire

/* File: tb/chamber_readout_control_bench.sv */
/*
 Bench for the chamber readout controller: random events, abort, refused
 reads, calibration, fast clear and card ORs.
 Assumes readout_pkg and card_chain_model are compiled first.
*/
`timescale 1ns/1ns
`default_nettype none
module chamber_readout_control_bench
    import readout_pkg::*;
;
    logic                  mclk, rst_n, cfg_wr, rd, ab, cal, fc, rc, pe;
    logic                  busy, load, done, late, perr, cala, tw, td, por, dor, lor;
    logic [3:0]            dt;
    logic [6:0]            idx;
    logic [7:0]            cnt;
    cfg_t                  cfg, rdback;
    card_pins_t            card;
    ctl_pins_t             ctl;
    hit_word_t             word, ew;
    hit_word_t             got [128];
    logic [3:0][31:0][8:0] img;
    int                    errors, samples_checked, seed, k, n, s, g, w;
    int                    nt, nd, np, nl, ny, found, nexp, mx;

    assign ctl = '{ret_clk: rc, data: dt, read: rd, abort: ab, cal: cal, fclr: fc};

    chamber_readout_control chamber_readout_control_inst (
        .mclk_in(mclk), .rst_n_in(rst_n), .ctl_pins_in(ctl), .card_pins_in(card),
        .cfg_wr_in(cfg_wr), .cfg_in(cfg), .rd_index_in(idx), .cfg_rdback_out(rdback),
        .rd_word_out(word), .word_count_out(cnt), .busy_out(busy), .xfer_load_out(load),
        .xfer_done_out(done), .xfer_late_out(late), .parity_err_out(perr),
        .cal_active_out(cala), .test_window_out(tw), .test_discard_out(td),
        .prompt_or_out(por), .delayed_or_out(dor), .latched_or_out(lor));

    card_chain_model card_chain_model_inst (
        .go_in(load), .stop_in(ab), .cards_in(cfg.cards), .img_in(img),
        .ret_clk_out(rc), .data_out(dt));

    // Clock at 20 MHz
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    task end_sim;
        if (errors == 0 && samples_checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : end_sim

    task chk(input string what, input logic [63:0] exp, input logic [63:0] seen);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task tick(input int c);
        repeat (c) @(negedge mclk);
    endtask : tick

    // Counts cycles with each test or diagnostic output high
    task watch(input int c);
        {nt, nd, np, nl, ny} = '0;
        repeat (c) begin
            @(negedge mclk);
            nt += tw; nd += td; np += por; nl += lor; ny += dor;
        end
    endtask : watch

    task wcfg;
        cfg_wr = 1'b1;
        tick(1);
        cfg_wr = 1'b0;
        tick(1);
        chk("cfg", 64'(cfg), 64'(rdback));
    endtask : wcfg

    task pulse_read;
        rd = 1'b1;
        tick(6);
        rd = 1'b0;
    endtask : pulse_read

    function hit_word_t exp_word(input int si, input int gi);
        return '{perr: ~^img[si][gi], loc: {2'(si), 5'(gi)}, hits: img[si][gi][8:1]};
    endfunction : exp_word

    // One event: random hits, read, then compare the stored words
    task run_ev(input int ev);
        for (s = 0; s < STREAMS; s++) begin
            cfg.cards[s] = (ev == 0) ? CARD_MAX : 5'(($random(seed) & 15) + (s == 0));
            mx = (s == 0 || cfg.cards[s] > mx) ? cfg.cards[s] : mx;
            for (g = 0; g < 32; g++) begin
                n = (($random(seed) & 3) == 0) ? ($random(seed) & 255) : 0;
                img[s][g] = {8'(n), ~^8'(n) ^ (ev == 3 && g == 1)};
            end
        end
        cfg.stream_mode = (ev == 2) ? 4'h3 : MODE_NORMAL;
        wcfg;
        pulse_read;
        for (k = 0; k < 20 && busy !== 1'b1; k++) tick(1);
        chk("busy", 1, busy);
        if (ev == 1) begin
            tick(50);
            pulse_read;
        end
        for (k = 0; k < 3000 && busy !== 1'b0; k++) tick(1);
        for (k = 0; k < 4 && done !== 1'b1; k++) tick(1);
        chk("done", 1, done);
        for (n = 0; n < cnt; n++) begin
            idx = 7'(n);
            tick(1);
            got[n] = word;
        end
        nexp = 0;
        pe = 1'b0;
        for (s = 0; s < STREAMS; s++)
            for (g = 0; g < 2 * cfg.cards[s]; g++)
                if (img[s][g][8:1] != 0 || cfg.stream_mode != MODE_NORMAL) begin
                    nexp++;
                    ew = exp_word(s, g);
                    pe |= ew.perr;
                    found = 0;
                    for (k = 0; k < cnt; k++)
                        if (got[k] === ew) found = 1;
                    chk("word", 1, found);
                end
        chk("count", nexp, cnt);
        chk("parity", pe, perr);
        // Link clock of 400 ns: one chain bit takes 400 / CLK_NS system clocks
        chk("late", BITS_PER_CARD * (400 / CLK_NS) * mx > XFER_LIMIT_CYC, late);
    endtask : run_ev

    // Main sequence
    initial begin
        seed = 20;
        errors = 0;
        samples_checked = 0;
        {cfg_wr, rd, ab, cal, fc} = '0;
        {cfg, card, idx, img} = '0;
        rst_n = 1'b0;
        tick(20);
        chk("busy", 0, busy);
        chk("count", 0, cnt);
        rst_n = 1'b1;
        tick(2);
        for (int ev = 0; ev < 5; ev++) run_ev(ev);
        // Abort in mid transfer of a full stream 0
        cfg.cards[0] = CARD_MAX;
        wcfg;
        pulse_read;
        tick(200);
        ab = 1'b1;
        tick(10);
        ab = 1'b0;
        for (k = 0; k < 20 && busy !== 1'b0; k++) tick(1);
        chk("abort busy", 0, busy);
        chk("abort count", 0, cnt);
        tick(20);
        // Calibration pairs and discards, read refused meanwhile
        w = 1 + ($random(seed) & 15);
        cfg.cal_mode = 2'h3;
        cfg.cal_width = 8'(w);
        cfg.cal_sep = 8'(w + 1 + ($random(seed) & 63));
        wcfg;
        cal = 1'b1;
        for (k = 0; k < 12 && cala !== 1'b1; k++) tick(1);
        chk("cal", 1, cala);
        pulse_read;
        chk("cal busy", 0, busy);
        watch(400);
        chk("window", 4 * w, nt);
        chk("discard", 2, nd);
        cal = 1'b0;
        for (k = 0; k < 260 && cala !== 1'b0; k++) tick(1);
        chk("cal end", 0, cala);
        // Fast clear
        fc = 1'b1;
        watch(15);
        fc = 1'b0;
        chk("fclr", 1, nd);
        // Card ORs: window with and without test enable, then comparator
        cfg.test_en = 16'h0001 << ($random(seed) & 15);
        wcfg;
        card.window = 1'b1;
        watch(10);
        chk("prompt", 1, np);
        card.window = 1'b0;
        cfg.test_en = '0;
        wcfg;
        card.window = 1'b1;
        watch(10);
        chk("prompt off", 0, np);
        card.comp = 16'($random(seed)) | 16'h8000;
        card.latch = 16'($random(seed)) | 16'h0100;
        card.delay = 16'($random(seed)) | 16'h0002;
        watch(10);
        chk("prompt comp", 1, np);
        chk("latched", 1, nl > 0);
        chk("delayed", 1, ny > 0);
        end_sim;
    end

    // Watchdog
    initial begin
        #(80000 * 50);
        errors++;
        end_sim;
    end
endmodule : chamber_readout_control_bench
`default_nettype wire
